/* crb_defines.vh */
`ifndef CRB_DEFINES_VH
`define CRB_DEFINES_VH
// register byte addresses (word aligned)
`define CRB_STATUS_OFF 4'h0
`define CRB_SID_OFF 4'h4
`define CRB_EID_OFF 4'h8
`define CRB_IRQ_STAT_OFF 4'hC
// second address bit group for event registers
`define CRB_IRQ_CLR_OFF 5'h10
`define CRB_IRQ_EN_OFF 5'h14
`define CRB_ADDR_W 5
// status register fields
`define CRB_FULL_BIT 7
`define CRB_RTR_BIT 3
`define CRB_FILT_HI 2
`define CRB_FILT_LO 0
// identifier register fields
`define CRB_SID_HI 12
`define CRB_SID_LO 2
`define CRB_SRR_BIT 1
`define CRB_XID_BIT 0
`define CRB_SID_MASK 16'h1FFF
`define CRB_EID_MASK 16'h0FFF
// event bits
`define CRB_EV_LOAD 0
`define CRB_EV_LOST 1
`define CRB_EV_W 2
// reset values
`define CRB_STATUS_RST 16'h0000
`define CRB_IRQ_RST 2'b00
`define CRB_FILT_RST 3'b000
// filter codes
`define CRB_FILT_ONE 3'b001
`endif

/* crb_event_bank.v */
`timescale 1ns/1ps
`include "crb_defines.vh"
module crb_event_bank #(
  parameter W = 2
) (
  input wire mclk,
  input wire resetn,
  input wire [W-1:0] ev_set,
  input wire clr_we,
  input wire en_we,
  input wire [W-1:0] wdata,
  output wire [W-1:0] stat,
  output wire [W-1:0] en,
  output wire irq_next
);
  reg [W-1:0] stat_reg;
  reg [W-1:0] en_reg;
  assign stat = stat_reg;
  assign en = en_reg;
  // next level so the top can register its output without a lag surprise
  assign irq_next = |((stat_reg & ~({W{clr_we}} & wdata) | ev_set)
    & (en_we ? wdata : en_reg));
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stat_reg <= {W{1'b0}};
      en_reg <= {W{1'b0}};
    end
    else
    begin
      // set wins over a clear in the same cycle
      stat_reg <= (stat_reg & ~({W{clr_we}} & wdata)) | ev_set;
      if (en_we)
        en_reg <= wdata;
    end
  end
endmodule // crb_event_bank

/* crb_rx_buffer.v */
`timescale 1ns/1ps
`include "crb_defines.vh"
module crb_rx_buffer (
  input wire mclk,
  input wire resetn,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg avs_response_err,
  input wire load_valid,
  input wire [2:0] load_filter,
  input wire load_rtr,
  input wire load_xid,
  input wire load_srr,
  input wire [10:0] load_sid,
  input wire [11:0] load_eid,
  input wire double_buffer_enable,
  output reg buffer_full_flag,
  output reg irq
);
  reg remote_request_seen_reg;
  reg [2:0] accepting_filter_number_reg;
  reg [15:0] sid_reg;
  reg [15:0] eid_reg;
  reg done_reg;
  reg [31:0] rdata_next;
  reg err_next;
  wire req;
  wire ack;
  wire acc_ok;
  wire load_take;
  wire [`CRB_EV_W-1:0] ev_set;
  wire [`CRB_EV_W-1:0] ev_stat;
  wire [`CRB_EV_W-1:0] ev_en;
  wire irq_next;
  wire wr_status;
  wire wr_sid;
  wire wr_eid;
  wire lo_bytes;

  // one wait cycle then answer; done_reg drops waitrequest for one edge
  assign req = (avs_read | avs_write) & ~done_reg;
  // writes land only at the edge the master sees waitrequest low
  assign ack = (avs_read | avs_write) & ~avs_waitrequest;
  assign lo_bytes = avs_byteenable[0] | avs_byteenable[1];
  assign wr_status = ack & avs_write & lo_bytes
    & (avs_address == {1'b0, `CRB_STATUS_OFF});
  assign wr_sid = ack & avs_write & lo_bytes
    & (avs_address == {1'b0, `CRB_SID_OFF});
  assign wr_eid = ack & avs_write & lo_bytes
    & (avs_address == {1'b0, `CRB_EID_OFF});

  // filters 0 and 1 only route here in double buffer mode; codes above
  // five do not exist and are dropped
  assign acc_ok = (load_filter > `CRB_FILT_ONE || double_buffer_enable)
    && load_filter <= 3'b101;
  // a full buffer is not overwritten, the message counts as lost
  assign load_take = load_valid & acc_ok & ~buffer_full_flag;
  assign ev_set = {load_valid & acc_ok & buffer_full_flag, load_take};

  crb_event_bank #(
    .W(`CRB_EV_W)
  ) u_events (
    .mclk(mclk),
    .resetn(resetn),
    .ev_set(ev_set),
    .clr_we(ack & avs_write & avs_byteenable[0]
      & (avs_address == `CRB_IRQ_CLR_OFF)),
    .en_we(ack & avs_write & avs_byteenable[0]
      & (avs_address == `CRB_IRQ_EN_OFF)),
    .wdata(avs_writedata[`CRB_EV_W-1:0]),
    .stat(ev_stat),
    .en(ev_en),
    .irq_next(irq_next)
  );

  always @*
  begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    case (avs_address)
      {1'b0, `CRB_STATUS_OFF}:
      begin
        rdata_next[`CRB_FULL_BIT] = buffer_full_flag;
        rdata_next[`CRB_RTR_BIT] = remote_request_seen_reg;
        rdata_next[`CRB_FILT_HI:`CRB_FILT_LO] =
          accepting_filter_number_reg;
      end
      {1'b0, `CRB_SID_OFF}:
        rdata_next[15:0] = sid_reg & `CRB_SID_MASK;
      {1'b0, `CRB_EID_OFF}:
        rdata_next[15:0] = eid_reg & `CRB_EID_MASK;
      {1'b0, `CRB_IRQ_STAT_OFF}:
        rdata_next[`CRB_EV_W-1:0] = ev_stat;
      `CRB_IRQ_CLR_OFF:
        rdata_next = 32'h0000_0000;
      `CRB_IRQ_EN_OFF:
        rdata_next[`CRB_EV_W-1:0] = ev_en;
      default:
        err_next = 1'b1;
    endcase
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      avs_response_err <= 1'b0;
      done_reg <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      done_reg <= req;
      avs_waitrequest <= ~req;
      if (req)
      begin
        avs_readdata <= avs_read ? rdata_next : 32'h0000_0000;
        avs_response_err <= err_next;
      end
      irq <= irq_next;
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      buffer_full_flag <= 1'b0;
      remote_request_seen_reg <= 1'b0;
      accepting_filter_number_reg <= `CRB_FILT_RST;
    end
    else
    begin
      if (load_take)
      begin
        buffer_full_flag <= 1'b1;
        remote_request_seen_reg <= load_rtr;
        accepting_filter_number_reg <= load_filter;
      end
      else if (wr_status && !avs_writedata[`CRB_FULL_BIT])
        buffer_full_flag <= 1'b0;
    end
  end

  // identifiers have no reset; contents unknown until first load or write
  always @(posedge mclk)
  begin
    if (load_take)
    begin
      sid_reg <= {3'b000, load_sid, load_srr, load_xid};
      eid_reg <= {4'h0, load_eid};
    end
    else
    begin
      if (wr_sid)
        sid_reg <= avs_writedata[15:0] & `CRB_SID_MASK;
      if (wr_eid)
        eid_reg <= avs_writedata[15:0] & `CRB_EID_MASK;
    end
  end
endmodule // crb_rx_buffer

/* crb_chk.sv */
`timescale 1ns/1ps
module crb_chk (
  input wire mclk, resetn, avs_read, avs_write, avs_waitrequest,
  input wire load_valid, double_buffer_enable, buffer_full_flag,
  input wire [4:0] avs_address,
  input wire [2:0] load_filter,
  input wire [31:0] avs_readdata
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  wire [31:0] q = avs_readdata;
  wire ans = avs_read && !avs_waitrequest;
  wire ok = load_filter < 3'h6 &&
    (load_filter > 3'h1 || double_buffer_enable);
  wire lf = load_valid && !buffer_full_flag;
  full_set_a: assert property (lf && ok |=> buffer_full_flag)
    else $error("no set");
  full_clr_a: assert property ($fell(buffer_full_flag) && $past(resetn)
    |-> $past(avs_write && !avs_waitrequest)) else $error("bad clear");
  full_keep_a: assert property (load_valid && buffer_full_flag
    |=> buffer_full_flag) else $error("overrun");
  filt_gate_a: assert property (lf && !ok |=> !buffer_full_flag)
    else $error("bad accept");
  filt_code_a: assert property (ans && avs_address == 5'h00
    |-> q[2:0] < 3'h6) else $error("bad code");
  stat_zero_a: assert property (ans && avs_address == 5'h00
    |-> q[31:8] == 0 && q[6:4] == 0) else $error("status");
  sid_zero_a: assert property (ans && avs_address == 5'h04
    |-> q[31:13] == 0) else $error("sid");
  eid_zero_a: assert property (ans && avs_address == 5'h08
    |-> q[31:12] == 0) else $error("eid");
endmodule // crb_chk
bind crb_rx_buffer crb_chk u_chk (.*);

/* crb_eng.sv */
`timescale 1ns/1ps
module crb_eng (
  input wire mclk,
  input wire go,
  input wire [28:0] msg,
  output reg load_valid,
  output reg [28:0] load_bus
);
  // fields inverted outside the pulse so stale data cannot pass
  always @(posedge mclk)
  begin
    load_valid <= go;
    load_bus <= go ? msg : ~msg;
  end
endmodule // crb_eng

/* tb.sv */
`timescale 1ns/1ps
module tb;
  reg mclk = 0, resetn = 0, avs_read = 0, avs_write = 0, go = 0;
  reg double_buffer_enable = 0;
  reg [3:0] avs_byteenable = 4'h3;
  reg [4:0] avs_address = 0;
  reg [31:0] avs_writedata = 0;
  reg [2:0] f = 0;
  reg [28:0] m = 0;
  wire avs_waitrequest, avs_response_err, load_valid, load_rtr;
  wire load_xid, load_srr, buffer_full_flag, irq;
  wire [31:0] avs_readdata;
  wire [2:0] load_filter;
  wire [10:0] load_sid, sx = 11'h5a5 ^ f;
  wire [11:0] load_eid, ex = 12'hc3c ^ f;
  integer err_count = 0, n_compared = 0;
  crb_eng u_eng (.mclk, .go, .msg(m), .load_valid, .load_bus({load_filter,
    load_rtr, load_xid, load_srr, load_sid, load_eid}));
  crb_rx_buffer u_dut (.*);
  initial forever #5 mclk = ~mclk;
  task c(input [31:0] g, input [31:0] e);
    n_compared = n_compared + 1;
    err_count = err_count + (g !== e);
    if (g !== e) $display("unexpected %0t %h %h", $time, g, e);
  endtask
  // for a read, d is the value expected back
  task b(input w, input [4:0] a, input [31:0] d);
    @(posedge mclk);
    avs_address <= a; avs_writedata <= d; avs_read <= !w; avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    if (!w) c(avs_readdata, d);
    c({31'h0, avs_response_err}, {31'h0, a > 5'h14 || a[1:0] != 2'b00});
    if (!w && a == 5'h00) c({31'h0, buffer_full_flag}, {31'h0, d[7]});
    avs_read <= 0; avs_write <= 0;
  endtask
  // irq follows its status in the same cycle; i still waits two edges before it checks
  task i(input e);
    repeat (2) @(posedge mclk);
    c({31'h0, irq}, {31'h0, e});
  endtask
  task l(input [5:0] k);
    @(posedge mclk); m <= {k, sx, ex}; go <= 1;
    @(posedge mclk); go <= 0;
    repeat (3) @(posedge mclk);
  endtask
  task t_codes;
    b(0, 5'h00, 32'h0);
    for (f = 2; f < 6; f = f + 1)
    begin
      l({f, f[0], f[0], f[1]});
      b(0, 5'h00, {24'h0, 4'h8, f[0], f});
      b(0, 5'h04, {19'h0, sx, f[1], f[0]});
      b(0, 5'h08, {20'h0, ex});
      b(1, 5'h00, 32'h80);
      b(0, 5'h00, {24'h0, 4'h8, f[0], f});
      b(1, 5'h00, 32'h0);
      b(0, 5'h00, {24'h0, 4'h0, f[0], f});
    end
  endtask
  task t_gate;
    b(1, 5'h10, 32'h3);
    l(6'h08);
    l(6'h30);
    b(0, 5'h00, 32'hd);
    double_buffer_enable <= 1;
    l(6'h00);
    i(0);
    b(1, 5'h14, 32'h1);
    i(1);
    l(6'h1c);
    b(0, 5'h00, 32'h80);
    b(0, 5'h0c, 32'h3);
    b(1, 5'h10, 32'h1);
    i(0);
    b(1, 5'h04, 32'hffff_ffff);
    b(0, 5'h04, 32'h1fff);
    b(0, 5'h18, 32'h0);
  endtask
  task results;
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #50000 err_count = err_count + 1;
    results;
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1;
    t_codes;
    t_gate;
    results;
  end
endmodule // tb
